// ===== pkg/lvtl_pkg.sv
// Constants and types shared by the low-voltage torque limit and overload timing block.
package lvtl_pkg;

    // Timing: the control tick is one millisecond of the 100 MHz clock.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Overload characteristic: ticks above the derated base current until the continuous alarm.
    localparam int OL_ALARM_MS = 10000;

    // Current scale: base current and the fixed instantaneous-overload level, in current units.
    localparam logic [15:0] BASE_CURRENT = 16'h0400;
    localparam logic [15:0] INST_CURRENT = 16'h0c00;
    localparam logic [23:0] PCT_SCALE = 24'h000064;

    // Register byte addresses.
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_LV_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_RELEASE = 8'h08;
    localparam logic [7:0] ADDR_HOLD = 8'h0c;
    localparam logic [7:0] ADDR_WARN_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_DERATE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h20;
    localparam logic [7:0] ADDR_RESTART = 8'h24;

    // Low-voltage handling modes.
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_HOST = 2'h1;
    localparam logic [1:0] MODE_SELF = 2'h2;

    // Reset values and setting ranges.
    localparam logic [1:0] MODE_RST = MODE_NONE;
    localparam logic [6:0] LV_LEVEL_RST = 7'h32;
    localparam logic [6:0] LV_LEVEL_MAX = 7'h64;
    localparam logic [9:0] RELEASE_RST = 10'h064;
    localparam logic [9:0] RELEASE_MAX = 10'h3e8;
    localparam logic [9:0] HOLD_RST = 10'h014;
    localparam logic [9:0] HOLD_MIN = 10'h014;
    localparam logic [9:0] HOLD_MAX = 10'h3e8;
    localparam logic [6:0] WARN_RST = 7'h14;
    localparam logic [6:0] WARN_MIN = 7'h01;
    localparam logic [6:0] WARN_MAX = 7'h64;
    localparam logic [6:0] DERATE_RST = 7'h64;
    localparam logic [6:0] DERATE_MIN = 7'h0a;
    localparam logic [6:0] DERATE_MAX = 7'h64;

    // Interrupt event bit positions.
    localparam int EV_LV_WARN = 0;
    localparam int EV_OL_WARN = 1;
    localparam int EV_OL_ALARM = 2;
    localparam int EV_INST_ALARM = 3;
    localparam int EV_POWER_OFF = 4;
    localparam int EV_W = 5;

    // Status register bit positions and the restart register bit.
    localparam int ST_LV_WARN = 0;
    localparam int ST_LV_LIMIT = 1;
    localparam int ST_OL_WARN = 2;
    localparam int ST_OL_ALARM = 3;
    localparam int ST_INST_ALARM = 4;
    localparam int ST_POWER_OFF = 5;
    localparam int ST_POWER_LOST = 6;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_MODE_PEND_LSB = 10;
    localparam int RESTART_BIT = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lvtl_bus_req_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [6:0] lv_level;
        logic [9:0] release_ms;
        logic [9:0] hold_ms;
        logic [6:0] warn_level;
        logic [6:0] derate;
    } lvtl_cfg_type;

    typedef enum logic [1:0] {
        LV_IDLE,
        LV_LIMIT,
        LV_RELEASE
    } lvtl_lv_state_type;

endpackage

// ===== verilog/lvtl_ms_tick.sv
// Millisecond tick generator for the protection timers.
module lvtl_ms_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    output logic tick_out
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } lvtl_tick_state_type;

    lvtl_tick_state_type state_reg;
    lvtl_tick_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (ce_in) begin
            state_next.tick = 1'b0;
            if (state_reg.cnt == CW'(CYCLES - 1)) begin
                state_next.cnt = '0;
                state_next.tick = 1'b1;
            end else begin
                state_next.cnt = state_reg.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;
endmodule

// ===== verilog/lvtl_top.sv
// Low-voltage torque limiting, power-cut hold and overload detection timing of a servo drive.
// What this block does
// - Factory mode: no low-voltage detection or limiting.
// - Independent mode: drive limits torque during warning.
// - After warning clears, release within set time.
// - Limit level 0 to 100 percent, immediate.
// - Release time 0 to 1000 ms, immediate.
// - Overload warning at set fraction of alarm time.
// - Overload warning drives general warning output.
// - Accumulate overload only above derated base current.
// - Derating 10 to 100 percent, after restart.
// - Derating change also shifts warning timing.
// - Instantaneous overload level fixed, never configurable.
// - Outage at least hold time turns power off.
//
// Implementation choices: the register addresses and the address-and-strobe port.
module lvtl_top #(
    parameter int TICK_CYCLES = lvtl_pkg::TICK_CYCLES,
    parameter int OL_ALARM_MS = lvtl_pkg::OL_ALARM_MS
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire lvtl_pkg::lvtl_bus_req_type bus_in,
    output logic [31:0] rd_data_out,
    input wire logic low_voltage_detect_in,
    input wire logic main_power_ok_in,
    input wire logic [15:0] motor_current_in,
    input wire logic [7:0] normal_torque_limit_in,
    output logic [7:0] torque_limit_out,
    output logic low_voltage_warning_out,
    output logic low_voltage_limit_active_out,
    output logic general_warning_out,
    output logic overload_alarm_out,
    output logic instant_overload_alarm_out,
    output logic motor_power_off_out,
    output logic irq_out
);
    import lvtl_pkg::*;

    localparam logic [15:0] ALARM_TICKS = 16'(OL_ALARM_MS);

    typedef struct packed {
        logic lv_meta;
        logic lv_sync;
        logic pw_meta;
        logic pw_sync;
        lvtl_cfg_type cfg;
        logic [1:0] mode_pend;
        logic [6:0] derate_pend;
        lvtl_lv_state_type lv_state;
        logic [9:0] rel_cnt;
        logic [9:0] out_cnt;
        logic power_off;
        logic [15:0] ol_acc;
        logic ol_warn;
        logic ol_alarm;
        logic inst_alarm;
        logic lv_warn;
        logic [7:0] torque_limit;
        logic [EV_W-1:0] int_status;
        logic [EV_W-1:0] int_mask;
        logic [31:0] rd_data;
    } lvtl_state_type;

    localparam lvtl_cfg_type CFG_RST = '{
        mode: MODE_RST,
        lv_level: LV_LEVEL_RST,
        release_ms: RELEASE_RST,
        hold_ms: HOLD_RST,
        warn_level: WARN_RST,
        derate: DERATE_RST
    };

    lvtl_state_type state_reg;
    lvtl_state_type state_next;
    logic tick;

    lvtl_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .tick_out(tick)
    );

    function automatic logic [6:0] clamp7(input logic [31:0] v, input logic [6:0] lo, input logic [6:0] hi);
        logic [6:0] r;
        if (v < 32'(lo)) begin
            r = lo;
        end else if (v > 32'(hi)) begin
            r = hi;
        end else begin
            r = v[6:0];
        end
        return r;
    endfunction

    function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] lo, input logic [9:0] hi);
        logic [9:0] r;
        if (v < 32'(lo)) begin
            r = lo;
        end else if (v > 32'(hi)) begin
            r = hi;
        end else begin
            r = v[9:0];
        end
        return r;
    endfunction

    logic mode_legal;
    logic warn_active;
    logic over_base;
    logic warn_reached;
    logic lv_limiting;
    logic restart;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] w1c;
    logic [31:0] status_word;
    logic [23:0] cur_scaled;
    logic [23:0] base_scaled;

    always_comb begin
        mode_legal = (state_reg.cfg.mode == MODE_HOST) || (state_reg.cfg.mode == MODE_SELF);
        // In the factory mode the detector input is ignored altogether.
        warn_active = mode_legal && state_reg.lv_sync;
        // Compare current against base times derating without a divider.
        cur_scaled = 24'(motor_current_in) * PCT_SCALE;
        base_scaled = 24'(BASE_CURRENT) * 24'(state_reg.cfg.derate);
        over_base = cur_scaled > base_scaled;
        // Warning time is a fraction of the alarm time, so derating shifts both.
        warn_reached = (24'(state_reg.ol_acc) * PCT_SCALE) >=
                       (24'(ALARM_TICKS) * 24'(state_reg.cfg.warn_level));
        lv_limiting = state_reg.lv_state != LV_IDLE;
        restart = bus_in.wr && (bus_in.addr == ADDR_RESTART) && bus_in.wdata[RESTART_BIT];
        status_word = '0;
        status_word[ST_LV_WARN] = state_reg.lv_warn;
        status_word[ST_LV_LIMIT] = lv_limiting;
        status_word[ST_OL_WARN] = state_reg.ol_warn;
        status_word[ST_OL_ALARM] = state_reg.ol_alarm;
        status_word[ST_INST_ALARM] = state_reg.inst_alarm;
        status_word[ST_POWER_OFF] = state_reg.power_off;
        status_word[ST_POWER_LOST] = !state_reg.pw_sync;
        status_word[ST_MODE_LSB +: 2] = state_reg.cfg.mode;
        status_word[ST_MODE_PEND_LSB +: 2] = state_reg.mode_pend;
    end

    always_comb begin
        state_next = state_reg;
        events = '0;
        w1c = '0;
        if (ce_in) begin
            state_next.lv_meta = low_voltage_detect_in;
            state_next.lv_sync = state_reg.lv_meta;
            state_next.pw_meta = main_power_ok_in;
            state_next.pw_sync = state_reg.pw_meta;
            state_next.rd_data = '0;

            // Warning reported to the host in both detecting modes.
            state_next.lv_warn = warn_active;
            if (warn_active && !state_reg.lv_warn) begin
                events[EV_LV_WARN] = 1'b1;
            end

            unique case (state_reg.lv_state)
                LV_IDLE: begin
                    if (warn_active && state_reg.cfg.mode == MODE_SELF) begin
                        state_next.lv_state = LV_LIMIT;
                    end
                end
                LV_LIMIT: begin
                    if (!state_reg.lv_sync) begin
                        state_next.rel_cnt = '0;
                        if (state_reg.cfg.release_ms == '0) begin
                            state_next.lv_state = LV_IDLE;
                        end else begin
                            state_next.lv_state = LV_RELEASE;
                        end
                    end
                end
                LV_RELEASE: begin
                    if (state_reg.lv_sync) begin
                        state_next.lv_state = LV_LIMIT;
                    end else if (tick) begin
                        state_next.rel_cnt = state_reg.rel_cnt + 10'h001;
                        if ((state_reg.rel_cnt + 10'h001) >= state_reg.cfg.release_ms) begin
                            state_next.lv_state = LV_IDLE;
                        end
                    end
                end
                default: begin
                    state_next.lv_state = LV_IDLE;
                end
            endcase
            if (state_reg.cfg.mode != MODE_SELF) begin
                state_next.lv_state = LV_IDLE;
            end

            if (lv_limiting && normal_torque_limit_in > {1'b0, state_reg.cfg.lv_level}) begin
                state_next.torque_limit = {1'b0, state_reg.cfg.lv_level};
            end else begin
                state_next.torque_limit = normal_torque_limit_in;
            end

            // Power-cut hold: an outage as long as the hold time removes motor power.
            if (state_reg.pw_sync) begin
                state_next.out_cnt = '0;
            end else if (tick && !state_reg.power_off) begin
                state_next.out_cnt = state_reg.out_cnt + 10'h001;
                if ((state_reg.out_cnt + 10'h001) >= state_reg.cfg.hold_ms) begin
                    state_next.power_off = 1'b1;
                    events[EV_POWER_OFF] = 1'b1;
                end
            end

            // Overload accumulates above the derated base and cools below it.
            if (tick) begin
                if (over_base) begin
                    if (state_reg.ol_acc < ALARM_TICKS) begin
                        state_next.ol_acc = state_reg.ol_acc + 16'h0001;
                    end
                end else if (state_reg.ol_acc != '0) begin
                    state_next.ol_acc = state_reg.ol_acc - 16'h0001;
                end
            end
            state_next.ol_warn = warn_reached && (state_reg.ol_acc != '0);
            if (state_next.ol_warn && !state_reg.ol_warn) begin
                events[EV_OL_WARN] = 1'b1;
            end
            if (state_reg.ol_acc >= ALARM_TICKS && !state_reg.ol_alarm) begin
                state_next.ol_alarm = 1'b1;
                events[EV_OL_ALARM] = 1'b1;
            end
            // The instantaneous level is a fixed constant, untouched by any setting.
            if (motor_current_in > INST_CURRENT && !state_reg.inst_alarm) begin
                state_next.inst_alarm = 1'b1;
                events[EV_INST_ALARM] = 1'b1;
            end

            if (bus_in.wr) begin
                unique case (bus_in.addr)
                    ADDR_MODE: begin
                        state_next.mode_pend = bus_in.wdata[1:0];
                    end
                    ADDR_LV_LEVEL: begin
                        state_next.cfg.lv_level = clamp7(bus_in.wdata, 7'h00, LV_LEVEL_MAX);
                    end
                    ADDR_RELEASE: begin
                        state_next.cfg.release_ms = clamp10(bus_in.wdata, 10'h000, RELEASE_MAX);
                    end
                    ADDR_HOLD: begin
                        state_next.cfg.hold_ms = clamp10(bus_in.wdata, HOLD_MIN, HOLD_MAX);
                    end
                    ADDR_WARN_LEVEL: begin
                        state_next.cfg.warn_level = clamp7(bus_in.wdata, WARN_MIN, WARN_MAX);
                    end
                    ADDR_DERATE: begin
                        state_next.derate_pend = clamp7(bus_in.wdata, DERATE_MIN, DERATE_MAX);
                    end
                    ADDR_INT_STATUS: begin
                        w1c = bus_in.wdata[EV_W-1:0];
                    end
                    ADDR_INT_MASK: begin
                        state_next.int_mask = bus_in.wdata[EV_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end

            // A restart applies the restart-only settings and clears latched trips.
            if (restart) begin
                state_next.cfg.mode = state_reg.mode_pend;
                state_next.cfg.derate = state_reg.derate_pend;
                state_next.ol_acc = '0;
                state_next.ol_warn = 1'b0;
                state_next.ol_alarm = 1'b0;
                state_next.inst_alarm = motor_current_in > INST_CURRENT;
                state_next.power_off = 1'b0;
                state_next.out_cnt = '0;
                state_next.lv_state = LV_IDLE;
            end

            // A new event wins over a clear in the same cycle.
            state_next.int_status = (state_reg.int_status & ~w1c) | events;

            if (bus_in.rd) begin
                unique case (bus_in.addr)
                    ADDR_MODE: state_next.rd_data = 32'(state_reg.mode_pend);
                    ADDR_LV_LEVEL: state_next.rd_data = 32'(state_reg.cfg.lv_level);
                    ADDR_RELEASE: state_next.rd_data = 32'(state_reg.cfg.release_ms);
                    ADDR_HOLD: state_next.rd_data = 32'(state_reg.cfg.hold_ms);
                    ADDR_WARN_LEVEL: state_next.rd_data = 32'(state_reg.cfg.warn_level);
                    ADDR_DERATE: state_next.rd_data = 32'(state_reg.derate_pend);
                    ADDR_STATUS: state_next.rd_data = status_word;
                    ADDR_INT_STATUS: state_next.rd_data = 32'(state_reg.int_status);
                    ADDR_INT_MASK: state_next.rd_data = 32'(state_reg.int_mask);
                    default: state_next.rd_data = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= '0;
            state_reg.pw_meta <= 1'b1;
            state_reg.pw_sync <= 1'b1;
            state_reg.cfg <= CFG_RST;
            state_reg.mode_pend <= MODE_RST;
            state_reg.derate_pend <= DERATE_RST;
            state_reg.lv_state <= LV_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_out = state_reg.rd_data;
    assign torque_limit_out = state_reg.torque_limit;
    assign low_voltage_warning_out = state_reg.lv_warn;
    assign low_voltage_limit_active_out = lv_limiting;
    assign general_warning_out = state_reg.ol_warn;
    assign overload_alarm_out = state_reg.ol_alarm;
    assign instant_overload_alarm_out = state_reg.inst_alarm;
    assign motor_power_off_out = state_reg.power_off;
    assign irq_out = |(state_reg.int_status & state_reg.int_mask);
endmodule

// ===== tb/lvtl_top_asserts.sv
// Concurrent checks on the ports of the low-voltage torque limit and overload timing block.
module lvtl_top_asserts #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire lvtl_pkg::lvtl_bus_req_type bus_in,
    input wire logic [31:0] rd_data_out,
    input wire logic low_voltage_detect_in,
    input wire logic main_power_ok_in,
    input wire logic [15:0] motor_current_in,
    input wire logic [7:0] normal_torque_limit_in,
    input wire logic [7:0] torque_limit_out,
    input wire logic low_voltage_warning_out,
    input wire logic low_voltage_limit_active_out,
    input wire logic overload_alarm_out,
    input wire logic instant_overload_alarm_out,
    input wire logic motor_power_off_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import lvtl_pkg::*;
    // The first hold tick may land just after the outage is synchronised, so allow one tick less.
    localparam int MIN_LOW = (int'(HOLD_MIN) - 1) * TICK_CYCLES;
    int low_cnt;
    logic restart_wr;
    assign restart_wr = bus_in.wr && bus_in.addr == ADDR_RESTART;
    always_ff @(posedge clock_in) begin
        if (rst_in || main_power_ok_in) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rd_data_out == 32'h0)
        else $error("read data not zero outside read answer");
    AST_INST_SET: assert property (motor_current_in > INST_CURRENT |=> instant_overload_alarm_out)
        else $error("instantaneous overload not flagged");
    AST_INST_HOLD: assert property (instant_overload_alarm_out && !restart_wr |=> instant_overload_alarm_out)
        else $error("instantaneous alarm dropped without restart");
    AST_OL_HOLD: assert property (overload_alarm_out && !restart_wr |=> overload_alarm_out)
        else $error("overload alarm dropped without restart");
    AST_PWR_HOLD: assert property (motor_power_off_out && !restart_wr |=> motor_power_off_out)
        else $error("power off dropped without restart");
    AST_PWR_TIME: assert property ($rose(motor_power_off_out) |-> low_cnt >= MIN_LOW)
        else $error("power off before hold time");
    AST_LV_CAUSE: assert property ($rose(low_voltage_warning_out) |-> $past(low_voltage_detect_in, 3))
        else $error("low-voltage warning without detector");
    AST_LIMIT_MIN: assert property ($past(low_voltage_limit_active_out) && low_voltage_limit_active_out
        |-> torque_limit_out <= $past(normal_torque_limit_in) && torque_limit_out <= 8'h64)
        else $error("limited torque above normal or full scale");
    AST_NO_LIMIT: assert property (!$past(rst_in) && !$past(low_voltage_limit_active_out)
        && !low_voltage_limit_active_out |-> torque_limit_out == $past(normal_torque_limit_in))
        else $error("torque limit differs from normal limit");
endmodule

// ===== tb/lvtl_host_model.sv
// Host controller model: commands torque, limits it on a low-voltage warning, sends servo-off.
module lvtl_host_model (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic host_limit_en_in,
    input wire logic [7:0] torque_cmd_in,
    input wire logic [7:0] host_limit_in,
    input wire logic lv_warning_in,
    input wire logic power_off_in,
    output logic [7:0] torque_limit_out,
    output logic servo_off_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            torque_limit_out <= 8'h00;
            servo_off_out <= 1'b0;
        end else begin
            torque_limit_out <= (host_limit_en_in && lv_warning_in) ? host_limit_in : torque_cmd_in;
            servo_off_out <= power_off_in;
        end
    end
endmodule

// ===== tb/lvtl_top_test.sv
// Self-checking bench for the low-voltage torque limit and overload timing block.
module lvtl_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lvtl_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    lvtl_bus_req_type bus = '0;
    logic lv_pin = 1'b0;
    logic pw_ok = 1'b1;
    logic [15:0] cur = 16'h0000;
    logic [7:0] cmd = 8'h50;
    logic host_en = 1'b0;
    logic [7:0] host_lim = 8'h28;
    logic [7:0] normal;
    logic [7:0] torque;
    logic [31:0] rd_data;
    logic lv_warn, lv_act, gen_warn, ol_alarm, inst_alarm, pwr_off, irq, servo_off;
    int fail_count = 0;
    int compares = 0;
    lvtl_top #(.TICK_CYCLES(10), .OL_ALARM_MS(20)) u_lvtl_top (.clock_in(clock_in), .rst_in(rst_in),
        .ce_in(1'b1), .bus_in(bus), .rd_data_out(rd_data), .low_voltage_detect_in(lv_pin),
        .main_power_ok_in(pw_ok), .motor_current_in(cur), .normal_torque_limit_in(normal),
        .torque_limit_out(torque), .low_voltage_warning_out(lv_warn), .low_voltage_limit_active_out(lv_act),
        .general_warning_out(gen_warn), .overload_alarm_out(ol_alarm), .instant_overload_alarm_out(inst_alarm),
        .motor_power_off_out(pwr_off), .irq_out(irq));
    lvtl_host_model u_lvtl_host_model (.clock_in(clock_in), .rst_in(rst_in), .host_limit_en_in(host_en),
        .torque_cmd_in(cmd), .host_limit_in(host_lim), .lv_warning_in(lv_warn), .power_off_in(pwr_off),
        .torque_limit_out(normal), .servo_off_out(servo_off));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus <= '0;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus <= '0;
        @(posedge clock_in);
        chk(rd_data, exp);
    endtask
    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset();
        rd(ADDR_MODE, 32'h0);
        rd(ADDR_LV_LEVEL, 32'h32);
        rd(ADDR_RELEASE, 32'h64);
        rd(ADDR_WARN_LEVEL, 32'h14);
        rd(ADDR_DERATE, 32'h64);
        rd(8'h30, 32'h0);
        chk(torque, 32'h50);
        $display("test reset done");
    endtask
    task automatic t_none();
        lv_pin <= 1'b1;
        cyc(10);
        chk(lv_warn, 32'h0);
        chk(torque, 32'h50);
        lv_pin <= 1'b0;
        cyc(5);
        $display("test factory mode done");
    endtask
    task automatic t_self();
        wr(ADDR_MODE, 32'h2);
        wr(ADDR_RESTART, 32'h1);
        wr(ADDR_HOLD, 32'h3e8);
        wr(ADDR_LV_LEVEL, 32'h7f);
        rd(ADDR_LV_LEVEL, 32'h64);
        wr(ADDR_RELEASE, 32'h7ff);
        rd(ADDR_RELEASE, 32'h3e8);
        wr(ADDR_LV_LEVEL, 32'h1e);
        wr(ADDR_RELEASE, 32'h2);
        lv_pin <= 1'b1;
        cyc(8);
        chk(lv_act, 32'h1);
        chk(torque, 32'h1e);
        lv_pin <= 1'b0;
        cyc(6);
        chk(torque, 32'h1e);
        cyc(40);
        chk(torque, 32'h50);
        wr(ADDR_RELEASE, 32'h0);
        lv_pin <= 1'b1;
        cyc(8);
        lv_pin <= 1'b0;
        cyc(7);
        chk(torque, 32'h50);
        $display("test drive limiting done");
    endtask
    task automatic t_host();
        wr(ADDR_MODE, 32'h1);
        wr(ADDR_RESTART, 32'h1);
        host_en <= 1'b1;
        lv_pin <= 1'b1;
        cyc(8);
        chk(lv_warn, 32'h1);
        chk(lv_act, 32'h0);
        chk(torque, 32'h28);
        chk(irq, 32'h0);
        lv_pin <= 1'b0;
        cyc(8);
        chk(torque, 32'h50);
        host_en <= 1'b0;
        $display("test host limiting done");
    endtask
    task automatic t_overload();
        wr(ADDR_INT_STATUS, 32'h1f);
        wr(ADDR_INT_MASK, 32'h2);
        wr(ADDR_WARN_LEVEL, 32'h32);
        cur <= 16'h0300;
        cyc(150);
        chk(gen_warn, 32'h0);
        wr(ADDR_DERATE, 32'h32);
        cyc(150);
        chk(gen_warn, 32'h0);
        wr(ADDR_RESTART, 32'h1);
        cyc(70);
        chk(gen_warn, 32'h0);
        cyc(50);
        chk(gen_warn, 32'h1);
        chk(irq, 32'h1);
        rd(ADDR_INT_STATUS, 32'h2);
        wr(ADDR_INT_STATUS, 32'h2);
        chk(irq, 32'h0);
        cyc(100);
        chk(ol_alarm, 32'h1);
        chk(irq, 32'h0);
        rd(ADDR_INT_STATUS, 32'h4);
        cur <= 16'h0000;
        wr(ADDR_RESTART, 32'h1);
        chk(ol_alarm, 32'h0);
        $display("test overload timing done");
    endtask
    task automatic t_inst();
        cur <= 16'h0c00;
        cyc(3);
        chk(inst_alarm, 32'h0);
        cur <= 16'h0c01;
        cyc(3);
        chk(inst_alarm, 32'h1);
        cur <= 16'h0000;
        wr(ADDR_RESTART, 32'h1);
        chk(inst_alarm, 32'h0);
        $display("test instantaneous overload done");
    endtask
    task automatic t_power();
        wr(ADDR_HOLD, 32'h5);
        rd(ADDR_HOLD, 32'h14);
        pw_ok <= 1'b0;
        cyc(170);
        pw_ok <= 1'b1;
        cyc(5);
        chk(pwr_off, 32'h0);
        pw_ok <= 1'b0;
        cyc(230);
        chk(pwr_off, 32'h1);
        chk(servo_off, 32'h1);
        pw_ok <= 1'b1;
        wr(ADDR_RESTART, 32'h1);
        $display("test power hold done");
    endtask
    initial begin
        cyc(6);
        rst_in <= 1'b0;
        cyc(1);
        t_reset();
        t_none();
        t_self();
        t_host();
        t_overload();
        t_inst();
        t_power();
        test_done();
    end
    initial begin
        cyc(20000);
        fail_count++;
        test_done();
    end
endmodule
bind lvtl_top lvtl_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_lvtl_top_asserts (.clock_in(clock_in),
    .rst_in(rst_in), .bus_in(bus_in), .rd_data_out(rd_data_out), .low_voltage_detect_in(low_voltage_detect_in),
    .main_power_ok_in(main_power_ok_in), .motor_current_in(motor_current_in),
    .normal_torque_limit_in(normal_torque_limit_in), .torque_limit_out(torque_limit_out),
    .low_voltage_warning_out(low_voltage_warning_out), .low_voltage_limit_active_out(low_voltage_limit_active_out),
    .overload_alarm_out(overload_alarm_out), .instant_overload_alarm_out(instant_overload_alarm_out),
    .motor_power_off_out(motor_power_off_out));
